// ==== src/serial_uart_port.sv ====
// serial receiver/transmitter with programmable bit period
// assumes register strobes on clk_i; interrupt controller lives outside
//
// Function
// - low fifteen period bits N give N+1 color clocks per bit
// - period top bit selects nine received data bits, else eight; transmit length is set by the word
// - period register cannot be read back
// - receive status word is sixteen readable bits of data and flags
// - bits shift in, then copy to holding register and flag data ready
// - shifter takes the next character right after the copy
// - bit 15 flags a character completing while full flag still set
// - bit 14 mirrors receive full request; software must clear it
// - bit 13 shows holding word empty; event only on becoming empty
// - bit 12 set when shifter idle and nothing left to send
// - bit 11 shows the receive pin level
// - bit 10 is unused
// - nine-bit mode puts the stop bit in bit 9
// - bit 8 is stop or ninth bit; bits 7-0 true data
// - transmit word write starts a frame with automatic start bit
// - shifter stops when only a one remains in the output position
// - an all-zero transmit word starts nothing
`timescale 1ns/10ps
module serial_uart_port (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register writes
  input  wire logic        period_wr_i,
  input  wire logic        transmit_wr_i,
  input  wire logic [15:0] wdata_i,
  // request bit clears from the interrupt request register
  input  wire logic        rx_full_clr_i,
  input  wire logic        overrun_clr_i,
  // register read
  output logic [15:0]      receive_status_word_o,
  // request bit set pulses
  output logic             rx_full_set_o,
  output logic             overrun_set_o,
  output logic             tx_empty_set_o,
  // serial pins
  input  wire logic        rxd_i,
  output logic             txd_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0]                                   serial_period_config;
  logic [serial_uart_pkg::CCK_CNT_W-1:0]         cck_cnt;
  logic                                          cck_en;
  logic                                          rx_s1;
  logic                                          rx_s2;
  logic                                          rx_s3;
  logic                                          rx_level;
  serial_uart_pkg::rx_state_t                    rx_state;
  logic [serial_uart_pkg::RX_SHIFT_W-1:0]        rx_shift;
  logic [serial_uart_pkg::RX_CNT_W-1:0]          rx_cnt;
  logic [serial_uart_pkg::STS_DATA_W-1:0]        rx_hold;
  logic                                          receive_full_flag;
  logic                                          receive_overrun_flag;
  logic [serial_uart_pkg::TX_WORD_W-1:0]         tx_hold;
  logic                                          tx_hold_full;
  logic [serial_uart_pkg::TX_SHIFT_W-1:0]        tx_shift;
  logic                                          tx_tail;
  logic                                          rx_tick;
  logic                                          tx_tick;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  wire logic [14:0] divider       = serial_period_config[14:0];
  wire logic        nine_bits     = serial_period_config[serial_uart_pkg::PER_LEN_BIT];
  wire logic        rx_fall       = (rx_s2 == rx_s3) && rx_level && !rx_s3;
  wire logic        rx_restart    = (rx_state == serial_uart_pkg::RX_IDLE) && rx_fall;
  wire logic [3:0]  rx_bits       = nine_bits ? serial_uart_pkg::RX_BITS_9
                                              : serial_uart_pkg::RX_BITS_8;
  wire logic        rx_sample     = rx_s3;
  wire logic [9:0]  rx_next_shift = {rx_sample, rx_shift[9:1]};
  wire logic        rx_done       = (rx_state == serial_uart_pkg::RX_DATA) && rx_tick
                                    && (rx_cnt == rx_bits - 4'h1);
  // eight-bit frames land one place high; realign so stop sits in bit 8
  wire logic [9:0]  rx_aligned    = nine_bits ? rx_next_shift
                                              : {1'b0, rx_next_shift[9:1]};
  wire logic        tx_idle       = (tx_shift == serial_uart_pkg::TX_SHIFT_IDLE);
  // last stop bit stands a full period before the next frame starts
  wire logic        tx_load       = tx_idle && tx_hold_full && !tx_tail;
  wire logic        tsr_empty     = tx_idle && !tx_hold_full && !tx_tail;

  // ----------------------------------------------------------------
  // color clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cck_cnt <= '0;
      cck_en  <= 1'b0;
    end else begin
      cck_en  <= (cck_cnt == serial_uart_pkg::CCK_CNT_W'(serial_uart_pkg::CCK_CYCLES - 1));
      cck_cnt <= (cck_cnt == serial_uart_pkg::CCK_CNT_W'(serial_uart_pkg::CCK_CYCLES - 1))
                 ? '0 : cck_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // period register, write only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_period_config <= serial_uart_pkg::PER_RESET;
    end else if (period_wr_i) begin
      serial_period_config <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1 <= rxd_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit period dividers
  // ----------------------------------------------------------------
  period_tick u_rx_tick (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .cck_en_i  (cck_en),
    .restart_i (rx_restart),
    .half_i    (1'b1),
    .divider_i (divider),
    .tick_o    (rx_tick)
  );

  period_tick u_tx_tick (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .cck_en_i  (cck_en),
    .restart_i (tx_load),
    .half_i    (1'b0),
    .divider_i (divider),
    .tick_o    (tx_tick)
  );

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_state <= serial_uart_pkg::RX_IDLE;
      rx_shift <= '0;
      rx_cnt   <= '0;
    end else begin
      case (rx_state)
        serial_uart_pkg::RX_IDLE: begin
          if (rx_fall) begin
            rx_state <= serial_uart_pkg::RX_START;
          end
        end
        serial_uart_pkg::RX_START: begin
          // mid start bit: a high level here was a glitch
          if (rx_tick) begin
            rx_state <= rx_sample ? serial_uart_pkg::RX_IDLE
                                  : serial_uart_pkg::RX_DATA;
            rx_cnt   <= '0;
          end
        end
        serial_uart_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_shift <= rx_next_shift;
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_done) begin
              rx_state <= serial_uart_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          rx_state <= serial_uart_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive holding register and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_hold              <= '0;
      receive_full_flag    <= 1'b0;
      receive_overrun_flag <= 1'b0;
      rx_full_set_o        <= 1'b0;
      overrun_set_o        <= 1'b0;
    end else begin
      rx_full_set_o <= rx_done;
      overrun_set_o <= rx_done && receive_full_flag;
      if (rx_done) begin
        rx_hold <= rx_aligned;
      end
      // set wins over a clear in the same cycle
      if (rx_done) begin
        receive_full_flag <= 1'b1;
      end else if (rx_full_clr_i) begin
        receive_full_flag <= 1'b0;
      end
      if (rx_done && receive_full_flag) begin
        receive_overrun_flag <= 1'b1;
      end else if (overrun_clr_i) begin
        receive_overrun_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit holding word and shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_hold        <= '0;
      tx_hold_full   <= 1'b0;
      tx_shift       <= serial_uart_pkg::TX_SHIFT_IDLE;
      tx_tail        <= 1'b0;
      tx_empty_set_o <= 1'b0;
      txd_o          <= 1'b1;
    end else begin
      tx_empty_set_o <= tx_load;
      if (transmit_wr_i && (wdata_i != 16'h0000)) begin
        tx_hold      <= wdata_i;
        tx_hold_full <= 1'b1;
      end else if (tx_load) begin
        tx_hold_full <= 1'b0;
      end
      if (tx_load) begin
        tx_shift <= {tx_hold, 1'b0};
        tx_tail  <= 1'b0;
      end else if (tx_tick && !tx_idle) begin
        tx_shift <= tx_shift >> 1;
        tx_tail  <= ((tx_shift >> 1) == serial_uart_pkg::TX_SHIFT_IDLE);
      end else if (tx_tick) begin
        tx_tail  <= 1'b0;
      end
      txd_o <= tx_load ? 1'b0 : tx_shift[0];
    end
  end

  // ----------------------------------------------------------------
  // receive status word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      receive_status_word_o <= 16'h3800;
    end else begin
      receive_status_word_o <= {receive_overrun_flag,
                                receive_full_flag,
                                !tx_hold_full,
                                tsr_empty,
                                rx_s3,
                                1'b0,
                                rx_hold};
    end
  end

endmodule : serial_uart_port

// ==== src/serial_uart_pkg.sv ====
// constants shared by the serial port and its bench
// assumes a single 125 MHz clock and a synchronous active-low reset
package serial_uart_pkg;

  // ----------------------------------------------------------------
  // clock and color clock timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned CCK_PERIOD_PS = 279400;
  // nearest whole count of system clocks per color clock
  localparam int unsigned CCK_CYCLES    =
    (CCK_PERIOD_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int unsigned CCK_CNT_W     = 6;

  // ----------------------------------------------------------------
  // serial_period_config fields
  // ----------------------------------------------------------------
  localparam int unsigned PER_DIV_W     = 15;
  localparam int unsigned PER_DIV_LSB   = 0;
  localparam int unsigned PER_LEN_BIT   = 15;
  localparam logic [15:0] PER_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // receive_status_word fields
  // ----------------------------------------------------------------
  localparam int unsigned STS_OVERRUN   = 15;
  localparam int unsigned STS_RX_FULL   = 14;
  localparam int unsigned STS_TX_EMPTY  = 13;
  localparam int unsigned STS_TSR_EMPTY = 12;
  localparam int unsigned STS_RX_PIN    = 11;
  localparam int unsigned STS_UNUSED    = 10;
  localparam int unsigned STS_DATA_W    = 10;

  // ----------------------------------------------------------------
  // shifters
  // ----------------------------------------------------------------
  localparam int unsigned RX_SHIFT_W    = 10;
  localparam int unsigned RX_CNT_W      = 4;
  localparam logic [3:0]  RX_BITS_8     = 4'h9;
  localparam logic [3:0]  RX_BITS_9     = 4'hA;
  localparam int unsigned TX_WORD_W     = 16;
  localparam int unsigned TX_SHIFT_W    = 17;
  localparam logic [16:0] TX_SHIFT_IDLE = 17'h00001;

  // ----------------------------------------------------------------
  // receiver states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA
  } rx_state_t;

endpackage : serial_uart_pkg

// ==== src/period_tick.sv ====
// bit-period divider: one tick every n+1 color clock enables
// assumes cck_en_i is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module period_tick (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        cck_en_i,
  input  wire logic        restart_i,
  input  wire logic        half_i,
  input  wire logic [14:0] divider_i,
  // output
  output logic             tick_o
);

  logic [14:0] count;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count  <= 15'h0000;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      count  <= half_i ? (divider_i >> 1) : divider_i;
      tick_o <= 1'b0;
    end else if (cck_en_i) begin
      tick_o <= (count == 15'h0000);
      count  <= (count == 15'h0000) ? divider_i : count - 15'h0001;
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule : period_tick

// ==== bench/serial_uart_port_props.sv ====
// checker on the serial port ports, bound into every instance
// assumes a bit period of two color clocks or more while sending
`timescale 1ns/10ps
module serial_uart_port_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // register side
  input wire logic        period_wr_i,
  input wire logic        transmit_wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        rx_full_clr_i,
  input wire logic        overrun_clr_i,
  input wire logic [15:0] receive_status_word_o,
  input wire logic        rx_full_set_o,
  input wire logic        overrun_set_o,
  input wire logic        tx_empty_set_o,
  // serial pins
  input wire logic        rxd_i,
  input wire logic        txd_o
);
  wire logic [15:0] sts  = receive_status_word_o;
  wire logic        idle = sts[12];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------
  // assertions
  // ------------------------------------------
  txd_idle_a: assert property (idle && $past(idle) |-> txd_o)
    else $error("txd low while shifter idle");
  tsr_holding_a: assert property (idle |-> sts[13])
    else $error("shifter empty with holding word full");
  unused_bit_a: assert property (sts[10] == 1'b0)
    else $error("unused status bit set");
  full_shown_a: assert property (rx_full_set_o |-> ##[1:2] sts[14])
    else $error("full flag not shown");
  full_clear_a: assert property (rx_full_clr_i && !rx_full_set_o |-> ##2 !sts[14])
    else $error("full flag not cleared");
  overrun_flag_a: assert property (overrun_set_o |-> rx_full_set_o ##[1:2] sts[15])
    else $error("overrun without completion or flag");
  tx_start_a: assert property (transmit_wr_i && wdata_i != 16'h0000 && idle && $past(idle)
    |-> ##[2:4] (tx_empty_set_o && !txd_o))
    else $error("transmit write did not start a frame");
  zero_write_a: assert property (transmit_wr_i && wdata_i == 16'h0000 && idle && $past(idle)
    |=> (txd_o && !tx_empty_set_o)[*8])
    else $error("zero write started a frame");
  start_len_a: assert property ($fell(txd_o) |-> !txd_o[*8])
    else $error("start bit too short");
  rx_pin_a: assert property ($stable(rxd_i)[*6] |-> sts[11] == rxd_i)
    else $error("pin bit differs from receive pin");
  cover property (overrun_set_o);
  cover property (tx_empty_set_o && !period_wr_i);
  cover property (rx_full_set_o ##[1:900] overrun_clr_i);
endmodule : serial_uart_port_props

bind serial_uart_port serial_uart_port_props serial_uart_port_props_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .period_wr_i(period_wr_i),
  .transmit_wr_i(transmit_wr_i), .wdata_i(wdata_i), .rx_full_clr_i(rx_full_clr_i),
  .overrun_clr_i(overrun_clr_i), .receive_status_word_o(receive_status_word_o),
  .rx_full_set_o(rx_full_set_o), .overrun_set_o(overrun_set_o),
  .tx_empty_set_o(tx_empty_set_o), .rxd_i(rxd_i), .txd_o(txd_o));

// ==== bench/serial_peer.sv ====
// remote serial peripheral: sends frames on rxd, samples frames on txd
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT_CYC = 70
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;
  // ------------------------------------------
  // frame tasks
  // ------------------------------------------
  task automatic send(input logic [11:0] bits, input int nb);
    rxd_o = 1'b0;
    repeat (BIT_CYC) @(posedge clk_i);
    #1;
    for (int i = 0; i < nb; i++) begin
      rxd_o = bits[i];
      repeat (BIT_CYC) @(posedge clk_i);
      #1;
    end
    rxd_o = 1'b1;
  endtask : send
  task automatic recv(output logic [15:0] w, input int nb);
    int t;
    t = 0;
    w = 16'h0000;
    while (txd_i !== 1'b0 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      w[i] = txd_i;
    end
    #1;
  endtask : recv
endmodule : serial_peer

// ==== bench/serial_uart_port_bench.sv ====
// self-checking bench for the serial port with a remote peer model
// assumes a color clock of 35 cycles and a period of two color clocks
`timescale 1ns/10ps
module serial_uart_port_bench;
  localparam int BIT_CYC = 2 * serial_uart_pkg::CCK_CYCLES;
  logic        clk_i         = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic        period_wr_i   = 1'b0;
  logic        transmit_wr_i = 1'b0;
  logic [15:0] wdata_i       = 16'h0000;
  logic        rx_full_clr_i = 1'b0;
  logic        overrun_clr_i = 1'b0;
  logic [15:0] sts;
  logic        rx_full_set_o;
  logic        overrun_set_o;
  logic        tx_empty_set_o;
  logic        rxd_i;
  logic        txd_o;
  logic [15:0] got;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          n_full    = 0;
  int          n_ovr     = 0;
  int          n_txe     = 0;
  int          cycles    = 0;

  always #4 clk_i = ~clk_i;

  serial_uart_port serial_uart_port_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .period_wr_i(period_wr_i),
    .transmit_wr_i(transmit_wr_i), .wdata_i(wdata_i), .rx_full_clr_i(rx_full_clr_i),
    .overrun_clr_i(overrun_clr_i), .receive_status_word_o(sts),
    .rx_full_set_o(rx_full_set_o), .overrun_set_o(overrun_set_o),
    .tx_empty_set_o(tx_empty_set_o), .rxd_i(rxd_i), .txd_o(txd_o));
  serial_peer #(.BIT_CYC(BIT_CYC)) serial_peer_inst (
    .clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // ------------------------------------------
  // pulse counters and timeout
  // ------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (rx_full_set_o === 1'b1) n_full++;
    if (overrun_set_o === 1'b1) n_ovr++;
    if (tx_empty_set_o === 1'b1) n_txe++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wr(input logic tx, input logic [15:0] d);
    period_wr_i = !tx;
    transmit_wr_i = tx;
    wdata_i = d;
    step(1);
    period_wr_i = 1'b0;
    transmit_wr_i = 1'b0;
  endtask : wr
  task automatic clr(input logic ovr);
    rx_full_clr_i = 1'b1;
    overrun_clr_i = ovr;
    step(1);
    rx_full_clr_i = 1'b0;
    overrun_clr_i = 1'b0;
    step(2);
  endtask : clr

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_reset();
    step(6);
    check(sts, 16'h3800, "reset status");
    check({15'h0000, txd_o}, 16'h0001, "idle line");
    wr(1'b0, 16'hFFFF);
    step(3);
    check(sts, 16'h3800, "period not readable");
  endtask : t_reset
  task automatic t_rx8();
    int f0;
    f0 = n_full;
    wr(1'b0, 16'h0001);
    serial_peer_inst.send(12'h1A5, 9);
    step(3);
    check(16'(n_full - f0), 16'h0001, "full pulses");
    check(sts & 16'hC3FF, 16'h41A5, "eight-bit char");
    clr(1'b0);
    check(sts & 16'h4000, 16'h0000, "full cleared");
  endtask : t_rx8
  task automatic t_rx9();
    wr(1'b0, 16'h8001);
    serial_peer_inst.send(12'h35A, 10);
    step(3);
    check(sts & 16'hC3FF, 16'h435A, "nine-bit char");
    clr(1'b0);
  endtask : t_rx9
  task automatic t_overrun();
    int o0;
    o0 = n_ovr;
    wr(1'b0, 16'h0001);
    serial_peer_inst.send(12'h13C, 9);
    serial_peer_inst.send(12'h1C3, 9);
    step(3);
    check(16'(n_ovr - o0), 16'h0001, "overrun pulses");
    check(sts & 16'hC3FF, 16'hC1C3, "second char kept");
    clr(1'b1);
    check(sts & 16'hC000, 16'h0000, "flags cleared");
  endtask : t_overrun
  task automatic t_tx();
    int t0;
    t0 = n_txe;
    wr(1'b1, 16'h0355);
    fork
      serial_peer_inst.recv(got, 10);
      begin
        step(6);
        wr(1'b1, 16'h03AA);
      end
    join
    check(got, 16'h0355, "first frame");
    check(sts & 16'h1000, 16'h0000, "second word pending");
    serial_peer_inst.recv(got, 10);
    check(got, 16'h03AA, "second frame");
    step(BIT_CYC);
    check(sts & 16'h3000, 16'h3000, "all sent");
    check(16'(n_txe - t0), 16'h0002, "empty events");
  endtask : t_tx
  task automatic t_zero();
    int t0;
    t0 = n_txe;
    wr(1'b1, 16'h0000);
    step(BIT_CYC);
    check(sts & 16'h3000, 16'h3000, "zero write idle");
    check(16'(n_txe - t0), 16'h0000, "zero write no load");
  endtask : t_zero

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  initial begin
    step(10);
    rst_n_i = 1'b1;
    t_reset();
    t_rx8();
    t_rx9();
    t_overrun();
    t_tx();
    t_zero();
    report_and_stop();
  end
endmodule : serial_uart_port_bench
